// ---- inc/cssc_pkg.sv ----
package cssc_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_CH = 16;
	localparam int CH_W = 4;
	localparam int DATA_W = 16;
	localparam int SUM_W = 22;
	localparam int CNT_W = 7;

	// ==========================================================
	// Start-of-conversion source codes
	localparam logic [2:0] SRC_BUSY = 3'h0;
	localparam logic [2:0] SRC_TMR0 = 3'h1;
	localparam logic [2:0] SRC_TMR2 = 3'h2;
	localparam logic [2:0] SRC_TMR1 = 3'h3;
	localparam logic [2:0] SRC_TMR3 = 3'h4;
	localparam logic [2:0] SRC_SINGLE_SCAN = 3'h5;
	localparam logic [2:0] SRC_CONT = 3'h6;
	localparam logic [2:0] SRC_CONT_SCAN = 3'h7;

	// ==========================================================
	// Timer overflow bit positions
	localparam int TMR0_BIT = 0;
	localparam int TMR1_BIT = 1;
	localparam int TMR2_BIT = 2;
	localparam int TMR3_BIT = 3;

	// ==========================================================
	// Conversion length codes and kept-bit masks
	localparam logic [1:0] LEN_12 = 2'h0;
	localparam logic [1:0] LEN_13 = 2'h1;
	localparam logic [1:0] LEN_14 = 2'h2;
	localparam logic [1:0] LEN_16 = 2'h3;
	localparam logic [1:0] LEN_RESET = LEN_13;
	localparam logic [15:0] MASK_12 = 16'hFFF0;
	localparam logic [15:0] MASK_13 = 16'hFFF8;
	localparam logic [15:0] MASK_14 = 16'hFFFC;
	localparam logic [15:0] MASK_16 = 16'hFFFF;

	// ==========================================================
	// Gain: code 0 is 1x up to code 7 for 8x
	localparam logic [2:0] GAIN_RESET = 3'h7;

	// ==========================================================
	// Accumulation codes: 1, 4, 8, 16, 32, 64 samples
	localparam logic [2:0] ACC_1 = 3'h0;
	localparam logic [2:0] ACC_4 = 3'h1;
	localparam logic [2:0] ACC_8 = 3'h2;
	localparam logic [2:0] ACC_16 = 3'h3;
	localparam logic [2:0] ACC_32 = 3'h4;
	localparam logic [2:0] ACC_64 = 3'h5;

	// ==========================================================
	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_START = 4'h2,
		ST_WAIT = 4'h4,
		ST_SETTLE = 4'h8
	} cssc_state_t;

endpackage

// ---- hw/cssc_accum.sv ----
`timescale 1ns/1ns
`default_nettype none

module cssc_accum (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control
	input wire logic clear,
	input wire logic [1:0] len_code,
	input wire logic [2:0] acc_code,
	// Samples
	input wire logic sample_valid,
	input wire logic [cssc_pkg::DATA_W-1:0] sample,
	// Result
	output logic acc_done,
	output logic [cssc_pkg::DATA_W-1:0] acc_result
);

	// ==========================================================
	// Length masking and set size
	logic [cssc_pkg::DATA_W-1:0] kept;
	logic [2:0] shift;
	logic [cssc_pkg::SUM_W-1:0] sum;
	logic [cssc_pkg::SUM_W-1:0] next_sum;
	logic [cssc_pkg::CNT_W-1:0] count;
	logic [cssc_pkg::CNT_W-1:0] target;

	always_comb begin
		unique case (len_code)
			cssc_pkg::LEN_12: kept = sample & cssc_pkg::MASK_12;
			cssc_pkg::LEN_13: kept = sample & cssc_pkg::MASK_13;
			cssc_pkg::LEN_14: kept = sample & cssc_pkg::MASK_14;
			cssc_pkg::LEN_16: kept = sample & cssc_pkg::MASK_16;
		endcase
	end

	always_comb begin
		case (acc_code)
			cssc_pkg::ACC_4: shift = 3'h2;
			cssc_pkg::ACC_8: shift = 3'h3;
			cssc_pkg::ACC_16: shift = 3'h4;
			cssc_pkg::ACC_32: shift = 3'h5;
			cssc_pkg::ACC_64: shift = 3'h6;
			default: shift = 3'h0;
		endcase
		target = 7'h01 << shift;
		next_sum = sum + {6'h00, kept};
	end

	// ==========================================================
	// Accumulate, divide on the last sample of a set
	always_ff @(posedge mclk) begin
		if (rst || clear) begin
			sum <= '0;
			count <= '0;
			acc_done <= 1'b0;
			acc_result <= '0;
		end else begin
			acc_done <= 1'b0;
			if (sample_valid) begin
				if (count + 7'h01 >= target) begin
					acc_done <= 1'b1;
					acc_result <= cssc_pkg::DATA_W'(next_sum >> shift);
					sum <= '0;
					count <= '0;
				end else begin
					sum <= next_sum;
					count <= count + 7'h01;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ---- hw/cssc_scan_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none

// Function
// - Eight conversion start sources chosen by the three-bit start mode field.
// - Continuous modes begin after busy set; complete interrupt when enabled.
// - Single scan converts each mask-enabled channel from the start channel upward once, end-of-scan after last.
// - Conversion length 12, 13, 14 or 16 bits, 13 at reset, rest zero.
// - With accumulation, completion interrupt only after the final conversion of set.
// - Multi-channel enable shorts all mask channels into one conversion.
// - Gain one to eight times in whole steps, eight after reset.
// - Mask scan wakes at end of scan (101) or each set (110, 111).
// - Mode 111 is range scan; start-channel write copies to mux; busy starts.
// - Range scan steps mux per set through end channel, then reloads start.
// - Range scan grounds other channels between start and end during conversion.
// - Range scan converts every mux channel; finishes rotation under debug halt.
// - Scanning keeps running in suspend; greater-than event may wake.
// - Mode 101 stops on touch holding that channel; busy write resumes.
// - Mode 101 stops after a clean pass; wakes if wake-on-interrupt set.
// - Greater flag follows result above threshold; interrupt when set, if enabled.
// - With accumulation, compare only after last conversion of set.
// - Greater flag during scan blocks further scan conversions until busy write.
// - Greater-than event wakes from suspend regardless of comparator interrupt enable.
module cssc_scan_ctrl (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Configuration
	input wire logic sense_enable,
	input wire logic [2:0] start_mode_field,
	input wire logic mask_scan_enable,
	input wire logic multi_channel_enable,
	input wire logic wake_on_interrupt,
	input wire logic [1:0] conv_length_field,
	input wire logic [2:0] gain_select,
	input wire logic [2:0] accum_select,
	input wire logic [7:0] scan_mask_low,
	input wire logic [7:0] scan_mask_high,
	input wire logic [cssc_pkg::CH_W-1:0] scan_end_channel,
	input wire logic [cssc_pkg::DATA_W-1:0] threshold,
	input wire logic complete_irq_enable,
	input wire logic greater_irq_enable,
	// Software strobes
	input wire logic busy_write,
	input wire logic start_write,
	input wire logic [cssc_pkg::CH_W-1:0] scan_start_channel,
	input wire logic mux_write,
	input wire logic [cssc_pkg::CH_W-1:0] mux_wdata,
	input wire logic complete_clear,
	input wire logic end_scan_clear,
	// System events
	input wire logic [3:0] timer_overflow,
	input wire logic debug_halt,
	// Analog front end
	input wire logic conv_done,
	input wire logic [cssc_pkg::DATA_W-1:0] conv_raw,
	output logic conv_start,
	output logic [cssc_pkg::CH_W-1:0] channel_mux,
	output logic [cssc_pkg::NUM_CH-1:0] ground_mask,
	output logic [cssc_pkg::NUM_CH-1:0] short_mask,
	output logic [2:0] gain_code,
	output logic [1:0] length_code,
	// Status and events
	output logic convert_busy_bit,
	output logic complete_flag,
	output logic end_scan_flag,
	output logic greater_than_flag,
	output logic [cssc_pkg::DATA_W-1:0] result,
	output logic complete_irq,
	output logic greater_irq,
	output logic wake_event
);

	// ==========================================================
	// Declarations
	cssc_pkg::cssc_state_t state;
	logic [cssc_pkg::NUM_CH-1:0] scan_mask;
	logic [cssc_pkg::CH_W-1:0] start_ch;
	logic range_scan;
	logic mask_scan;
	logic cont_mode;
	logic trig;
	logic accept;
	logic acc_done;
	logic [cssc_pkg::DATA_W-1:0] acc_result;
	logic is_greater;
	logic [cssc_pkg::CH_W-1:0] nxt_ch;
	logic nxt_wrap;
	logic stop_now;
	logic eos_now;
	logic wake_now;
	logic [cssc_pkg::CH_W-1:0] next_mux;
	logic [cssc_pkg::NUM_CH-1:0] next_ground;

	assign scan_mask = {scan_mask_high, scan_mask_low};

	// ==========================================================
	// Mode decode
	always_comb begin
		range_scan = !mask_scan_enable && !multi_channel_enable
			&& start_mode_field == cssc_pkg::SRC_CONT_SCAN;
		mask_scan = mask_scan_enable && !multi_channel_enable
			&& (start_mode_field == cssc_pkg::SRC_SINGLE_SCAN
			|| start_mode_field == cssc_pkg::SRC_CONT
			|| start_mode_field == cssc_pkg::SRC_CONT_SCAN);
		cont_mode = start_mode_field == cssc_pkg::SRC_CONT
			|| start_mode_field == cssc_pkg::SRC_CONT_SCAN;
	end

	// ==========================================================
	// Start source selection
	always_comb begin
		unique case (start_mode_field)
			cssc_pkg::SRC_TMR0: trig = timer_overflow[cssc_pkg::TMR0_BIT];
			cssc_pkg::SRC_TMR2: trig = timer_overflow[cssc_pkg::TMR2_BIT];
			cssc_pkg::SRC_TMR1: trig = timer_overflow[cssc_pkg::TMR1_BIT];
			cssc_pkg::SRC_TMR3: trig = timer_overflow[cssc_pkg::TMR3_BIT];
			cssc_pkg::SRC_BUSY,
			cssc_pkg::SRC_SINGLE_SCAN,
			cssc_pkg::SRC_CONT,
			cssc_pkg::SRC_CONT_SCAN: trig = 1'b0;
		endcase
		// Continuous modes wait for the busy write, never a timer
		accept = sense_enable && state == cssc_pkg::ST_IDLE
			&& (busy_write || trig);
	end

	// ==========================================================
	// Next enabled mask channel after the current one
	function automatic logic [cssc_pkg::CH_W:0] next_enabled(
		input logic [cssc_pkg::NUM_CH-1:0] mask,
		input logic [cssc_pkg::CH_W-1:0] cur
	);
		logic [cssc_pkg::CH_W-1:0] idx;
		logic found;
		logic [cssc_pkg::CH_W:0] res;
		found = 1'b0;
		res = {1'b1, cur};
		for (int i = 1; i <= cssc_pkg::NUM_CH; i++) begin
			idx = cur + cssc_pkg::CH_W'(i);
			if (!found && mask[idx]) begin
				found = 1'b1;
				res = {(idx <= cur), idx};
			end
		end
		return res;
	endfunction

	// ==========================================================
	// Set evaluation
	always_comb begin
		is_greater = acc_result > threshold;
		{nxt_wrap, nxt_ch} = next_enabled(scan_mask, channel_mux);
		stop_now = 1'b1;
		eos_now = 1'b0;
		wake_now = is_greater;
		next_mux = channel_mux;
		if ((range_scan || mask_scan) && is_greater) begin
			stop_now = 1'b1;
		end else if (mask_scan) begin
			next_mux = nxt_ch;
			if (start_mode_field == cssc_pkg::SRC_SINGLE_SCAN) begin
				stop_now = nxt_wrap;
				eos_now = nxt_wrap;
				if (nxt_wrap && wake_on_interrupt) begin
					wake_now = 1'b1;
				end
			end else begin
				stop_now = 1'b0;
				if (wake_on_interrupt) begin
					wake_now = 1'b1;
				end
			end
		end else if (range_scan) begin
			if (channel_mux == scan_end_channel) begin
				next_mux = start_ch;
				// Halting mid-rotation would leave the mux unknown to firmware
				stop_now = debug_halt;
			end else begin
				next_mux = channel_mux + 4'h1;
				stop_now = 1'b0;
			end
		end else if (cont_mode) begin
			stop_now = 1'b0;
		end
	end

	// ==========================================================
	// Grounding of idle channels inside the scan range
	for (genvar g = 0; g < cssc_pkg::NUM_CH; g++) begin : gen_gnd
		assign next_ground[g] = range_scan && state != cssc_pkg::ST_IDLE
			&& g >= start_ch && g <= scan_end_channel
			&& g != channel_mux;
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= cssc_pkg::ST_IDLE;
		end else if (!sense_enable) begin
			state <= cssc_pkg::ST_IDLE;
		end else begin
			unique case (state)
				cssc_pkg::ST_IDLE: begin
					if (accept) begin
						state <= cssc_pkg::ST_START;
					end
				end
				cssc_pkg::ST_START: begin
					state <= cssc_pkg::ST_WAIT;
				end
				cssc_pkg::ST_WAIT: begin
					if (conv_done) begin
						state <= cssc_pkg::ST_SETTLE;
					end
				end
				cssc_pkg::ST_SETTLE: begin
					if (acc_done && stop_now) begin
						state <= cssc_pkg::ST_IDLE;
					end else begin
						state <= cssc_pkg::ST_START;
					end
				end
				default: state <= cssc_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			conv_start <= 1'b0;
		end else begin
			conv_start <= sense_enable && state == cssc_pkg::ST_START;
		end
	end

	// ==========================================================
	// Accumulator and divider
	cssc_accum u_accum (
		.mclk(mclk),
		.rst(rst),
		.clear(accept),
		.len_code(length_code),
		.acc_code(accum_select),
		.sample_valid(state == cssc_pkg::ST_WAIT && conv_done),
		.sample(conv_raw),
		.acc_done(acc_done),
		.acc_result(acc_result)
	);

	// ==========================================================
	// Channel selection
	always_ff @(posedge mclk) begin
		if (rst) begin
			channel_mux <= '0;
			start_ch <= '0;
		end else begin
			if (start_write) begin
				start_ch <= scan_start_channel;
			end
			if (start_write && (range_scan || mask_scan)) begin
				channel_mux <= scan_start_channel;
			end else if (mux_write && state == cssc_pkg::ST_IDLE) begin
				channel_mux <= mux_wdata;
			end else if (state == cssc_pkg::ST_SETTLE && acc_done) begin
				channel_mux <= next_mux;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ground_mask <= '0;
			short_mask <= '0;
		end else begin
			ground_mask <= next_ground;
			short_mask <= multi_channel_enable ? scan_mask : '0;
		end
	end

	// ==========================================================
	// Front-end settings
	always_ff @(posedge mclk) begin
		if (rst) begin
			gain_code <= cssc_pkg::GAIN_RESET;
			length_code <= cssc_pkg::LEN_RESET;
		end else begin
			gain_code <= gain_select;
			length_code <= conv_length_field;
		end
	end

	// ==========================================================
	// Busy and completion flags, hardware set wins over clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			convert_busy_bit <= 1'b0;
		end else if (!sense_enable) begin
			convert_busy_bit <= 1'b0;
		end else if (accept) begin
			convert_busy_bit <= 1'b1;
		end else if (state == cssc_pkg::ST_SETTLE && acc_done && stop_now) begin
			convert_busy_bit <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			complete_flag <= 1'b0;
			end_scan_flag <= 1'b0;
		end else begin
			if (state == cssc_pkg::ST_SETTLE && acc_done) begin
				complete_flag <= 1'b1;
			end else if (complete_clear) begin
				complete_flag <= 1'b0;
			end
			if (state == cssc_pkg::ST_SETTLE && acc_done && eos_now) begin
				end_scan_flag <= 1'b1;
			end else if (end_scan_clear) begin
				end_scan_flag <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Comparator and result
	always_ff @(posedge mclk) begin
		if (rst) begin
			greater_than_flag <= 1'b0;
			result <= '0;
		end else if (state == cssc_pkg::ST_SETTLE && acc_done) begin
			greater_than_flag <= is_greater;
			result <= acc_result;
		end
	end

	// ==========================================================
	// Interrupt and wake lines
	always_ff @(posedge mclk) begin
		if (rst) begin
			complete_irq <= 1'b0;
			greater_irq <= 1'b0;
			wake_event <= 1'b0;
		end else begin
			complete_irq <= complete_irq_enable
				&& state == cssc_pkg::ST_SETTLE && acc_done;
			greater_irq <= greater_irq_enable
				&& state == cssc_pkg::ST_SETTLE && acc_done && is_greater;
			// Wake ignores the comparator interrupt enable on purpose
			wake_event <= state == cssc_pkg::ST_SETTLE && acc_done
				&& wake_now;
		end
	end

endmodule

`default_nettype wire

// ---- testbench/cssc_props.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Port checker
module cssc_props (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Watched inputs
	input wire logic sense_enable,
	input wire logic [2:0] start_mode_field,
	input wire logic busy_write,
	input wire logic [3:0] timer_overflow,
	input wire logic [2:0] gain_select,
	input wire logic [1:0] conv_length_field,
	input wire logic multi_channel_enable,
	input wire logic [7:0] scan_mask_low,
	input wire logic [7:0] scan_mask_high,
	input wire logic [15:0] threshold,
	input wire logic complete_irq_enable,
	input wire logic greater_irq_enable,
	// Watched outputs
	input wire logic conv_start,
	input wire logic convert_busy_bit,
	input wire logic complete_flag,
	input wire logic end_scan_flag,
	input wire logic greater_than_flag,
	input wire logic [15:0] result,
	input wire logic complete_irq,
	input wire logic greater_irq,
	input wire logic [15:0] short_mask,
	input wire logic [2:0] gain_code,
	input wire logic [1:0] length_code
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic trig;
	assign trig = busy_write || (start_mode_field == 3'h1 && timer_overflow[0])
		|| (start_mode_field == 3'h2 && timer_overflow[2])
		|| (start_mode_field == 3'h3 && timer_overflow[1])
		|| (start_mode_field == 3'h4 && timer_overflow[3]);
	sequence launch_s;
		##1 convert_busy_bit ##1 conv_start;
	endsequence
	start_lat_a: assert property (sense_enable && !convert_busy_bit && trig |-> launch_s)
		else $error("start latency wrong");
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("start pulse too long");
	idle_quiet_a: assert property (!convert_busy_bit |=> !conv_start)
		else $error("start while idle");
	gain_follow_a: assert property (!$past(rst) |-> gain_code == $past(gain_select))
		else $error("gain code wrong");
	len_follow_a: assert property (!$past(rst) |-> length_code == $past(conv_length_field))
		else $error("length code wrong");
	short_mask_a: assert property (!$past(rst) && $past(multi_channel_enable)
		|-> short_mask == {$past(scan_mask_high), $past(scan_mask_low)})
		else $error("short mask wrong");
	cpl_irq_a: assert property (complete_irq |-> complete_flag && $past(complete_irq_enable))
		else $error("complete irq wrong");
	gt_irq_a: assert property (greater_irq |-> greater_than_flag && $past(greater_irq_enable))
		else $error("greater irq wrong");
	gt_compare_a: assert property ($changed(result) |-> greater_than_flag == (result > threshold))
		else $error("compare flag wrong");
	scan_end_a: assert property ($rose(end_scan_flag)
		|-> !convert_busy_bit && $past(start_mode_field) == 3'h5)
		else $error("end of scan wrong");
endmodule

bind cssc_scan_ctrl cssc_props cssc_props_inst (.*);

`default_nettype wire

// ---- testbench/cssc_pad_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Electrode and front-end model
module cssc_pad_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Front end
	input wire logic conv_start,
	input wire logic [cssc_pkg::CH_W-1:0] channel_mux,
	output logic conv_done,
	output logic [cssc_pkg::DATA_W-1:0] conv_raw,
	// Electrode setup
	input wire logic [cssc_pkg::CH_W-1:0] touch_ch,
	input wire logic [cssc_pkg::DATA_W-1:0] touch_val,
	input wire logic [cssc_pkg::DATA_W-1:0] idle_val
);
	logic [2:0] wait_cnt;
	// Every channel answers, analog or not; never in the start cycle
	always_ff @(posedge mclk) begin
		if (rst || conv_start) begin
			wait_cnt <= rst ? 3'h0 : 3'h3;
		end else if (wait_cnt != 3'h0) begin
			wait_cnt <= wait_cnt - 3'h1;
		end
	end
	// Data toggles outside the answer so a stale read cannot match
	always_ff @(posedge mclk) begin
		conv_done <= !rst && wait_cnt == 3'h1;
		if (rst) begin
			conv_raw <= 16'h5A5A;
		end else begin
			conv_raw <= wait_cnt == 3'h1 ? (channel_mux == touch_ch ? touch_val : idle_val) : ~conv_raw;
		end
	end
endmodule

`default_nettype wire

// ---- testbench/capacitive_sense_scan_control_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module capacitive_sense_scan_control_tb;
	logic mclk = 1'b0, rst = 1'b1, sense_enable = 1'b0, mask_scan_enable = 1'b0;
	logic multi_channel_enable = 1'b0, wake_on_interrupt = 1'b0, debug_halt = 1'b0;
	logic [2:0] start_mode_field = 3'h0, gain_select = 3'h7, accum_select = 3'h0;
	logic [1:0] conv_length_field = 2'h1;
	logic [7:0] scan_mask_low = 8'h00, scan_mask_high = 8'h00;
	logic [3:0] scan_end_channel = 4'h0, scan_start_channel = 4'h0, mux_wdata = 4'h0;
	logic [3:0] timer_overflow = 4'h0, touch_ch = 4'hF, channel_mux;
	logic [15:0] threshold = 16'h4000, touch_val = 16'h9000, idle_val = 16'h123F;
	logic complete_irq_enable = 1'b1, greater_irq_enable = 1'b1, busy_write = 1'b0;
	logic start_write = 1'b0, mux_write = 1'b0, complete_clear = 1'b0, end_scan_clear = 1'b0;
	logic clr_cnt = 1'b0;
	logic conv_done, conv_start, convert_busy_bit, complete_flag, end_scan_flag;
	logic greater_than_flag, complete_irq, greater_irq, wake_event, cs_d = 1'b0;
	logic [15:0] conv_raw, ground_mask, short_mask, result, gm3 = 16'h0000;
	logic [2:0] gain_code;
	logic [1:0] length_code;
	logic [3:0] q [$];
	logic [3:0] rexp [4] = '{4'h2, 4'h3, 4'h4, 4'h2};
	logic [15:0] masks [4] = '{cssc_pkg::MASK_12, cssc_pkg::MASK_13, cssc_pkg::MASK_14,
		cssc_pkg::MASK_16};
	int tbits [4] = '{cssc_pkg::TMR0_BIT, cssc_pkg::TMR2_BIT, cssc_pkg::TMR1_BIT,
		cssc_pkg::TMR3_BIT};
	int n_mismatch = 0, checks_done = 0, cyc = 0, n_ci = 0, n_gi = 0, n_wk = 0;

	cssc_scan_ctrl cssc_scan_ctrl_inst (.*);
	cssc_pad_model cssc_pad_model_inst (.*);

	always #5 mclk = ~mclk;

	// ==========================================================
	// Event monitor and hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		cs_d <= conv_start;
		if (cs_d === 1'b1 && channel_mux === 4'h3) gm3 <= ground_mask;
		// Cleared only here so the counts keep a single writer
		if (clr_cnt) begin
			q.delete();
			n_ci <= 0;
			n_gi <= 0;
			n_wk <= 0;
		end else begin
			if (conv_start === 1'b1) q.push_back(channel_mux);
			n_ci <= n_ci + (complete_irq === 1'b1);
			n_gi <= n_gi + (greater_irq === 1'b1);
			n_wk <= n_wk + (wake_event === 1'b1);
		end
		if (cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// Access tasks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task launch(input int tb);
		@(posedge mclk);
		complete_clear <= 1'b1;
		end_scan_clear <= 1'b1;
		clr_cnt <= 1'b1;
		@(posedge mclk);
		complete_clear <= 1'b0;
		end_scan_clear <= 1'b0;
		clr_cnt <= 1'b0;
		@(posedge mclk);
		if (tb < 0) busy_write <= 1'b1;
		else timer_overflow[tb] <= 1'b1;
		@(posedge mclk);
		busy_write <= 1'b0;
		timer_overflow <= 4'h0;
	endtask
	task set_start(input logic [3:0] ch);
		@(posedge mclk);
		start_write <= 1'b1;
		scan_start_channel <= ch;
		@(posedge mclk);
		start_write <= 1'b0;
	endtask
	task wait_idle;
		int i;
		repeat (3) @(negedge mclk);
		for (i = 0; i < 3000 && convert_busy_bit !== 1'b0; i++) @(negedge mclk);
		// Event pulses are counted one edge after they stand
		repeat (2) @(negedge mclk);
		chk({15'h0000, convert_busy_bit}, 16'h0000);
	endtask
	task wait_q(input int n);
		int i;
		for (i = 0; i < 3000 && q.size() < n; i++) @(negedge mclk);
		chk(16'(q.size() >= n), 16'h0001);
	endtask
	task abort;
		@(posedge mclk);
		sense_enable <= 1'b0;
		repeat (3) @(negedge mclk);
		chk({15'h0000, convert_busy_bit}, 16'h0000);
		@(posedge mclk);
		sense_enable <= 1'b1;
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		int i;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk({13'h0000, gain_code}, 16'h0007);
		chk({14'h0000, length_code}, 16'h0001);
		@(posedge mclk);
		rst <= 1'b0;
		sense_enable <= 1'b1;
		@(posedge mclk);
		start_mode_field <= cssc_pkg::SRC_BUSY;
		@(posedge mclk);
		gain_select <= 3'h2;
		repeat (2) @(negedge mclk);
		chk({13'h0000, gain_code}, 16'h0002);
		$display("reset test done");
		for (i = 0; i < 4; i++) begin
			@(posedge mclk);
			conv_length_field <= 2'(i);
			launch(-1);
			wait_idle();
			chk(result, idle_val & masks[i]);
			chk({15'h0000, complete_flag}, 16'h0001);
			chk(16'(n_ci), 16'h0001);
		end
		$display("length test done");
		accum_select <= cssc_pkg::ACC_4;
		launch(-1);
		wait_idle();
		chk(16'(q.size()), 16'h0004);
		chk(16'(n_ci), 16'h0001);
		chk(result, idle_val);
		accum_select <= cssc_pkg::ACC_1;
		$display("accumulate test done");
		for (i = 0; i < 4; i++) begin
			@(posedge mclk);
			start_mode_field <= 3'(i + 1);
			launch(tbits[(i + 1) % 4]);
			repeat (4) @(negedge mclk);
			chk({15'h0000, convert_busy_bit}, 16'h0000);
			launch(tbits[i]);
			wait_idle();
			chk(16'(n_ci), 16'h0001);
		end
		$display("timer test done");
		start_mode_field <= cssc_pkg::SRC_BUSY;
		complete_irq_enable <= 1'b0;
		greater_irq_enable <= 1'b0;
		touch_ch <= 4'h0;
		launch(-1);
		wait_idle();
		chk({15'h0000, greater_than_flag}, 16'h0001);
		chk(16'(n_gi), 16'h0000);
		chk(16'(n_wk), 16'h0001);
		chk(16'(n_ci), 16'h0000);
		greater_irq_enable <= 1'b1;
		complete_irq_enable <= 1'b1;
		launch(-1);
		wait_idle();
		chk(16'(n_gi), 16'h0001);
		touch_ch <= 4'hF;
		$display("compare test done");
		start_mode_field <= cssc_pkg::SRC_CONT;
		launch(-1);
		wait_q(3);
		chk({12'h000, q[2]}, 16'h0000);
		abort();
		$display("continuous test done");
		start_mode_field <= cssc_pkg::SRC_CONT_SCAN;
		scan_end_channel <= 4'h4;
		set_start(4'h2);
		launch(-1);
		wait_q(5);
		touch_ch <= 4'h3;
		wait_idle();
		for (i = 0; i < 4; i++) chk({12'h000, q[i]}, {12'h000, rexp[i]});
		chk({12'h000, channel_mux}, 16'h0003);
		chk(gm3, 16'h0014);
		repeat (20) @(negedge mclk);
		chk(16'(q.size()), 16'h0005);
		touch_ch <= 4'hF;
		launch(-1);
		wait_q(2);
		chk({12'h000, q[0]}, 16'h0003);
		chk({12'h000, q[1]}, 16'h0004);
		// A halt during the rotation lets it end at the end channel
		debug_halt <= 1'b1;
		wait_idle();
		chk(16'(q.size()), 16'h0002);
		chk({12'h000, channel_mux}, 16'h0002);
		debug_halt <= 1'b0;
		abort();
		$display("range scan test done");
		start_mode_field <= cssc_pkg::SRC_SINGLE_SCAN;
		mask_scan_enable <= 1'b1;
		scan_mask_low <= 8'h22;
		scan_mask_high <= 8'h02;
		wake_on_interrupt <= 1'b1;
		set_start(4'h1);
		launch(-1);
		wait_idle();
		chk(16'(q.size()), 16'h0003);
		chk({4'h0, q[0], q[1], q[2]}, 16'h0159);
		chk({15'h0000, end_scan_flag}, 16'h0001);
		chk(16'(n_wk), 16'h0001);
		multi_channel_enable <= 1'b1;
		launch(-1);
		wait_idle();
		chk(16'(q.size()), 16'h0001);
		chk(short_mask, 16'h0222);
		$display("mask scan test done");
		sense_enable <= 1'b0;
		tally_and_finish();
	end
endmodule

`default_nettype wire
